// ===== hdl/shc_map.vh
`ifndef SHC_MAP_VH
`define SHC_MAP_VH

// ==========================================================================
// Register offsets (byte addresses)
`define SHC_MODE_OFS 8'h5c
`define SHC_STAT_OFS 8'h60

// ==========================================================================
// Mode register fields and reset value
`define SHC_MODE_RST 8'h80
`define SHC_WDT_EN_BIT 7
`define SHC_WDT_PER_HI 6
`define SHC_WDT_PER_LO 5
`define SHC_WARM_BIT 4
`define SHC_HALT_HI 3
`define SHC_HALT_LO 2
`define SHC_WDT_INTERNAL_RESET_CTL_BIT 1
`define SHC_DRIVE_BIT 0

// ==========================================================================
// Halt mode encodings
`define SHC_HM_CPU 2'b00
`define SHC_HM_STOP 2'b01
`define SHC_HM_OSC 2'b10
`define SHC_HM_PART 2'b11

// ==========================================================================
// Timing counts
`define SHC_ENTRY_CLKS 2'h3
`define SHC_WARM_SHORT_CNT 17'h0_4000
`define SHC_WARM_LONG_CNT 17'h1_0000

// ==========================================================================
// AHB encodings
`define SHC_HTRANS_NONSEQ 2'h2
`define SHC_HTRANS_SEQ 2'h3

`endif

// ===== hdl/shc_wake_latch.v
`timescale 1ns/1ps
`include "shc_map.vh"

// ==========================================================================
// Sticky hold of a wake request; a new request wins over a clear
module shc_wake_latch (
  hclk,
  hresetn,
  set_i,
  clr_i,
  held_o
);
  input wire hclk;
  input wire hresetn;
  input wire set_i;
  input wire clr_i;
  output wire held_o;

  reg held_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held_q <= 1'b0;
    end else if (set_i) begin
      held_q <= 1'b1;
    end else if (clr_i) begin
      held_q <= 1'b0;
    end
  end

  assign held_o = held_q;
endmodule // shc_wake_latch

// ===== hdl/shc_warmup.v
`timescale 1ns/1ps
`include "shc_map.vh"

// ==========================================================================
// Oscillator warm-up counter, counts oscillator ticks
module shc_warmup #(
  parameter [16:0] SHORT_CNT = `SHC_WARM_SHORT_CNT,
  parameter [16:0] LONG_CNT = `SHC_WARM_LONG_CNT
) (
  hclk,
  hresetn,
  start_i,
  long_i,
  osc_tick_i,
  done_o
);
  input wire hclk;
  input wire hresetn;
  input wire start_i;
  input wire long_i;
  input wire osc_tick_i;
  output reg done_o;

  reg [16:0] cnt_q;
  reg [16:0] lim_q;
  reg run_q;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt_q <= 17'h0_0000;
      lim_q <= 17'h0_0000;
      run_q <= 1'b0;
      done_o <= 1'b0;
    end else begin
      done_o <= 1'b0;
      if (start_i) begin
        cnt_q <= 17'h0_0000;
        lim_q <= long_i ? LONG_CNT : SHORT_CNT;
        run_q <= 1'b1;
      end else if (run_q && osc_tick_i) begin
        if (cnt_q == lim_q - 17'h0_0001) begin
          run_q <= 1'b0;
          done_o <= 1'b1;
        end
        cnt_q <= cnt_q + 17'h0_0001;
      end
    end
  end
endmodule // shc_warmup

// ===== hdl/shc_standby.v
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ps
`include "shc_map.vh"

// Overview of operation
// - Halt instruction enters the state chosen by the two-bit halt mode field
// - Mode bit 7 enables the watchdog; it resets set
// - Warm-up bit picks 2^14 or 2^16 oscillator cycles of wait
// - Internal reset control bit routes watchdog timeout to internal reset
// - Pin-drive bit: ports float in full stop when 0, stay driven when 1
// - CPU-only halt keeps clocks, stops execution, samples interrupts
// - Partial idle: selected peripherals clocked; non-watchdog, non-converter
// - Oscillator idle: clock stops, only wake pins release, resume is synchronous
// - Full stop halts all; wake release restarts clock after warm-up
// - Interrupt at or above mask releases CPU-only halt, or partial halt unless watchdog or converter, is serviced, then continues
// - Masked interrupts do not release, except wake pins: no service
// - Wake during three-clock entry to oscillator idle or full stop is held; later interrupt releases
// - Reset releases any halt and initialises all settings
// - Full stop: oscillator pins high, inputs gated, clock out floats when pin-drive bit is 0
module shc_standby #(
  parameter [16:0] WARM_SHORT_CNT = `SHC_WARM_SHORT_CNT,
  parameter [16:0] WARM_LONG_CNT = `SHC_WARM_LONG_CNT
) (
  hclk,
  hresetn,
  hsel,
  haddr,
  htrans,
  hwrite,
  hsize,
  hwdata,
  hready,
  hrdata,
  hreadyout,
  hresp,
  halt_exec,
  processor_interrupt_mask,
  irq_req,
  irq_level,
  irq_is_watchdog,
  irq_is_converter,
  wake_interrupt_a,
  wake_interrupt_b,
  osc_tick,
  wdt_timeout,
  cpu_halted,
  cpu_resume,
  cpu_service,
  sys_clk_en,
  periph_clk_en,
  osc_en,
  watchdog_enable_bit,
  watchdog_period,
  wdt_internal_reset,
  port_oe,
  clk_out_oe,
  osc_out_high,
  input_gate_en,
  wake_held
);
  input wire hclk;
  input wire hresetn;
  input wire hsel;
  input wire [7:0] haddr;
  input wire [1:0] htrans;
  input wire hwrite;
  input wire [2:0] hsize;
  input wire [31:0] hwdata;
  input wire hready;
  output reg [31:0] hrdata;
  output reg hreadyout;
  output reg hresp;
  input wire halt_exec;
  input wire [2:0] processor_interrupt_mask;
  input wire irq_req;
  input wire [2:0] irq_level;
  input wire irq_is_watchdog;
  input wire irq_is_converter;
  input wire wake_interrupt_a;
  input wire wake_interrupt_b;
  input wire osc_tick;
  input wire wdt_timeout;
  output reg cpu_halted;
  output reg cpu_resume;
  output reg cpu_service;
  output reg sys_clk_en;
  output reg periph_clk_en;
  output reg osc_en;
  output reg watchdog_enable_bit;
  output reg [1:0] watchdog_period;
  output reg wdt_internal_reset;
  output reg port_oe;
  output reg clk_out_oe;
  output reg osc_out_high;
  output reg input_gate_en;
  output reg wake_held;

  // ========================================================================
  // States
  localparam [2:0] ST_RUN = 3'h0;
  localparam [2:0] ST_ENTER = 3'h1;
  localparam [2:0] ST_HALT = 3'h2;
  localparam [2:0] ST_WARM = 3'h3;
  localparam [2:0] ST_WAKE = 3'h4;

  // ========================================================================
  // Register bus slave
  reg [7:0] mode_q;
  reg [7:0] addr_q;
  reg wr_q;
  reg [2:0] state_q;
  reg [2:0] state_d;
  reg [1:0] hmode_q;
  reg [1:0] ecnt_q;
  reg svc_q;
  wire a_held;
  wire b_held;
  wire warm_done;
  wire acc;
  wire [31:0] rd_d;

  assign acc = hsel && hready &&
    (htrans == `SHC_HTRANS_NONSEQ || htrans == `SHC_HTRANS_SEQ);
  assign rd_d = (haddr == `SHC_MODE_OFS) ? {24'h00_0000, mode_q} :
    (haddr == `SHC_STAT_OFS) ?
    {24'h00_0000, 1'b0, b_held, a_held, hmode_q, state_q} :
    32'h0000_0000;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      addr_q <= 8'h00;
      wr_q <= 1'b0;
      hrdata <= 32'h0000_0000;
      hreadyout <= 1'b0;
      hresp <= 1'b0;
      mode_q <= `SHC_MODE_RST;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      wr_q <= acc && hwrite;
      if (acc) begin
        addr_q <= haddr;
      end
      if (acc && !hwrite) begin
        hrdata <= rd_d;
      end
      if (wr_q && addr_q == `SHC_MODE_OFS) begin
        mode_q <= hwdata[7:0];
      end
    end
  end

  // ========================================================================
  // Release qualification
  wire [1:0] sel_mode;
  wire enabled_irq;
  wire wake_now;
  wire part_ok;
  wire rel_cpu;
  wire rel_part;
  wire rel_osc;

  assign sel_mode = {mode_q[`SHC_HALT_HI], mode_q[`SHC_HALT_LO]};
  assign enabled_irq = irq_req &&
    (irq_level >= processor_interrupt_mask);
  assign wake_now = wake_interrupt_a || wake_interrupt_b;
  assign part_ok = enabled_irq && !irq_is_watchdog &&
    !irq_is_converter;
  assign rel_cpu = enabled_irq || wake_now;
  assign rel_part = part_ok || wake_now;
  assign rel_osc = wake_now;

  // ========================================================================
  // Held wake requests during entry
  wire in_entry;
  wire clr_held;

  assign in_entry = (state_q == ST_ENTER) &&
    (hmode_q == `SHC_HM_OSC || hmode_q == `SHC_HM_STOP);
  assign clr_held = (state_q == ST_WAKE);

  shc_wake_latch u_hold_a (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_i(in_entry && wake_interrupt_a),
    .clr_i(clr_held),
    .held_o(a_held)
  );

  shc_wake_latch u_hold_b (
    .hclk(hclk),
    .hresetn(hresetn),
    .set_i(in_entry && wake_interrupt_b),
    .clr_i(clr_held),
    .held_o(b_held)
  );

  // ========================================================================
  // Warm-up wait
  shc_warmup #(
    .SHORT_CNT(WARM_SHORT_CNT),
    .LONG_CNT(WARM_LONG_CNT)
  ) u_warm (
    .hclk(hclk),
    .hresetn(hresetn),
    .start_i(state_q == ST_HALT && hmode_q == `SHC_HM_STOP &&
      rel_osc),
    .long_i(mode_q[`SHC_WARM_BIT]),
    .osc_tick_i(osc_tick),
    .done_o(warm_done)
  );

  // ========================================================================
  // Halt state machine
  reg rel_now;

  always @* begin
    case (hmode_q)
      `SHC_HM_CPU: rel_now = rel_cpu;
      `SHC_HM_PART: rel_now = rel_part;
      `SHC_HM_OSC: rel_now = rel_osc;
      `SHC_HM_STOP: rel_now = rel_osc;
      default: rel_now = 1'b0;
    endcase
  end

  always @* begin
    state_d = state_q;
    case (state_q)
      ST_RUN: begin
        if (halt_exec) begin
          state_d = ST_ENTER;
        end
      end
      ST_ENTER: begin
        if (ecnt_q == `SHC_ENTRY_CLKS - 2'h1) begin
          state_d = ST_HALT;
        end
      end
      ST_HALT: begin
        if (rel_now) begin
          if (hmode_q == `SHC_HM_STOP) begin
            state_d = ST_WARM;
          end else begin
            state_d = ST_WAKE;
          end
        end
      end
      ST_WARM: begin
        if (warm_done) begin
          state_d = ST_WAKE;
        end
      end
      ST_WAKE: begin
        state_d = ST_RUN;
      end
      default: begin
        state_d = ST_RUN;
      end
    endcase
  end

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= ST_RUN;
      hmode_q <= `SHC_HM_CPU;
      ecnt_q <= 2'h0;
      svc_q <= 1'b0;
    end else begin
      state_q <= state_d;
      if (state_q == ST_RUN && halt_exec) begin
        hmode_q <= sel_mode;
      end
      if (state_q == ST_ENTER) begin
        ecnt_q <= ecnt_q + 2'h1;
      end else begin
        ecnt_q <= 2'h0;
      end
      if (state_q == ST_HALT && rel_now) begin
        svc_q <= enabled_irq;
      end
    end
  end

  // ========================================================================
  // Registered outputs
  wire halted_d;
  wire in_stop;
  wire clk_on;

  assign halted_d = (state_d != ST_RUN) && (state_d != ST_WAKE);
  assign in_stop = halted_d && state_d != ST_ENTER &&
    hmode_q == `SHC_HM_STOP;
  assign clk_on = !halted_d || state_d == ST_ENTER ||
    hmode_q == `SHC_HM_CPU || hmode_q == `SHC_HM_PART;

  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cpu_halted <= 1'b0;
      cpu_resume <= 1'b0;
      cpu_service <= 1'b0;
      sys_clk_en <= 1'b1;
      periph_clk_en <= 1'b1;
      osc_en <= 1'b1;
      watchdog_enable_bit <= 1'b1;
      watchdog_period <= 2'h0;
      wdt_internal_reset <= 1'b0;
      port_oe <= 1'b1;
      clk_out_oe <= 1'b1;
      osc_out_high <= 1'b0;
      input_gate_en <= 1'b1;
      wake_held <= 1'b0;
    end else begin
      cpu_halted <= halted_d;
      cpu_resume <= (state_d == ST_WAKE);
      // Service decision is taken at the release edge itself; svc_q
      // only carries it across the warm-up wait of full stop
      if (state_q == ST_HALT) begin
        cpu_service <= (state_d == ST_WAKE) && enabled_irq;
      end else begin
        cpu_service <= (state_d == ST_WAKE) && svc_q;
      end
      sys_clk_en <= clk_on;
      periph_clk_en <= !halted_d || state_d == ST_ENTER ||
        hmode_q != `SHC_HM_STOP && hmode_q != `SHC_HM_OSC;
      osc_en <= !in_stop && state_d != ST_WARM ||
        state_d == ST_WARM;
      watchdog_enable_bit <= mode_q[`SHC_WDT_EN_BIT];
      watchdog_period <= {mode_q[`SHC_WDT_PER_HI],
        mode_q[`SHC_WDT_PER_LO]};
      wdt_internal_reset <= mode_q[`SHC_WDT_INTERNAL_RESET_CTL_BIT] &&
        wdt_timeout;
      port_oe <= !in_stop || mode_q[`SHC_DRIVE_BIT];
      clk_out_oe <= !in_stop || mode_q[`SHC_DRIVE_BIT];
      osc_out_high <= in_stop;
      input_gate_en <= !in_stop;
      wake_held <= a_held || b_held;
    end
  end
endmodule // shc_standby

// ===== bench/shc_standby_assertions.sv
`timescale 1ns/1ps
// ==========================================================================
// Port checker for the standby controller
module shc_chk (
  input logic hclk,
  input logic hresetn,
  input logic halt_exec,
  input logic cpu_halted,
  input logic cpu_resume,
  input logic cpu_service,
  input logic sys_clk_en,
  input logic periph_clk_en,
  input logic port_oe,
  input logic clk_out_oe,
  input logic osc_out_high,
  input logic input_gate_en,
  input logic wdt_timeout,
  input logic wdt_internal_reset,
  input logic watchdog_enable_bit
);
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  halt_entry_a: assert property (
    halt_exec && !cpu_halted |=> cpu_halted)
    else $error("halt not entered");
  resume_pulse_a: assert property (
    cpu_resume |=> !cpu_resume)
    else $error("resume longer than one cycle");
  resume_src_a: assert property (
    cpu_resume |-> $past(cpu_halted))
    else $error("resume without halt");
  service_pair_a: assert property (
    cpu_service |-> cpu_resume)
    else $error("service without resume");
  clocks_run_a: assert property (
    !cpu_halted && !cpu_resume |-> sys_clk_en && periph_clk_en)
    else $error("clock off while running");
  wdt_route_a: assert property (
    wdt_internal_reset |-> $past(wdt_timeout))
    else $error("internal reset without timeout");
  wdt_after_rst_a: assert property (
    $rose(hresetn) |-> watchdog_enable_bit)
    else $error("watchdog off after reset");
  stop_pins_a: assert property (
    !port_oe |-> osc_out_high && !input_gate_en)
    else $error("ports off outside stop");
  clk_float_a: assert property (
    clk_out_oe == port_oe)
    else $error("clock out enable differs");
  stop_clock_a: assert property (
    osc_out_high |-> cpu_halted && !sys_clk_en)
    else $error("clock on in stop");
  cover property (cpu_service);
  cover property (cpu_resume && !cpu_service);
  cover property (!port_oe);
endmodule // shc_chk

// ===== bench/shc_irq_model.sv
`timescale 1ns/1ps
// ==========================================================================
// Interrupt controller: request stands until serviced
module shc_irq_model (
  input logic hclk,
  input logic hresetn,
  input logic raise,
  input logic [2:0] lvl,
  input logic cpu_service,
  output logic irq_req,
  output logic [2:0] irq_level
);
  always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      irq_req <= 1'b0;
      irq_level <= 3'h0;
    end else if (raise) begin
      irq_req <= 1'b1;
      irq_level <= lvl;
    end else if (cpu_service) begin
      irq_req <= 1'b0;
    end else if (!irq_req) begin
      irq_level <= ~irq_level;
    end
  end
endmodule // shc_irq_model

// ===== bench/tb.sv
`timescale 1ns/1ps
`include "shc_map.vh"
// ==========================================================================
// Standby controller bench
module tb;
  localparam int SH = 16;
  localparam int LG = 64;
  logic hclk = 0, hresetn = 0, hsel, hwrite, hready, hreadyout, hresp;
  logic [7:0] haddr;
  logic [1:0] htrans, watchdog_period;
  logic [2:0] hsize, processor_interrupt_mask, irq_level, lvl;
  logic [31:0] hwdata, hrdata, r;
  logic halt_exec, irq_req, irq_is_watchdog, irq_is_converter, raise;
  logic wake_interrupt_a, wake_interrupt_b, osc_tick, wdt_timeout;
  logic cpu_halted, cpu_resume, cpu_service, sys_clk_en, periph_clk_en;
  logic osc_en, watchdog_enable_bit, wdt_internal_reset, port_oe;
  logic clk_out_oe, osc_out_high, input_gate_en, wake_held;
  int error_cnt = 0, n_compared = 0, n;
  assign hready = hreadyout;
  always #20 hclk = ~hclk;
  always @(posedge hclk) osc_tick <= ~osc_tick;
  shc_standby #(.WARM_SHORT_CNT(17'h0_0010), .WARM_LONG_CNT(17'h0_0040))
    DUT (.*);
  shc_irq_model u_irq (.hclk(hclk), .hresetn(hresetn), .raise(raise),
    .lvl(lvl), .cpu_service(cpu_service), .irq_req(irq_req),
    .irq_level(irq_level));
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1; haddr <= a; htrans <= `SHC_HTRANS_NONSEQ; hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  task automatic halt(input logic [1:0] hm, input logic [7:0] x);
    bus(1, `SHC_MODE_OFS, {24'h0, x | {4'h0, hm, 2'h0}}, r);
    halt_exec <= 1; @(posedge hclk); halt_exec <= 0;
    repeat (6) @(posedge hclk);
    chk(cpu_halted, 1);
  endtask
  task automatic irq(input logic [2:0] l);
    raise <= 1; lvl <= l; @(posedge hclk); raise <= 0;
  endtask
  task automatic wres();
    n = 0;
    while (cpu_resume !== 1'b1 && n < 400) begin
      @(posedge hclk); n++;
    end
    if (n >= 400) error_cnt++;
  endtask
  task automatic t_reg();
    bus(0, `SHC_MODE_OFS, 0, r); chk(r, 32'h0000_0080);
    chk(hresp, 0);
    bus(1, `SHC_MODE_OFS, 32'h0000_0062, r);
    bus(0, `SHC_MODE_OFS, 0, r); chk(r, 32'h0000_0062);
    chk(watchdog_enable_bit, 0);
    chk(watchdog_period, 2'h3);
    wdt_timeout <= 1; repeat (3) @(posedge hclk);
    chk(wdt_internal_reset, 1);
    bus(1, `SHC_MODE_OFS, 0, r); repeat (2) @(posedge hclk);
    chk(wdt_internal_reset, 0);
    wdt_timeout <= 0;
    bus(0, 8'h40, 0, r); chk(r, 0);
    $display("t_reg done");
  endtask
  task automatic t_cpu();
    halt(`SHC_HM_CPU, 0); chk(sys_clk_en, 1);
    irq(3'h2); repeat (8) @(posedge hclk); chk(cpu_halted, 1);
    irq(3'h5); wres(); chk(n < 4, 1);
    chk(cpu_service, 1);
    halt(`SHC_HM_PART, 0); chk(periph_clk_en, 1);
    irq_is_watchdog <= 1; irq(3'h5); repeat (8) @(posedge hclk);
    chk(cpu_halted, 1);
    irq_is_watchdog <= 0; irq_is_converter <= 1;
    repeat (8) @(posedge hclk); chk(cpu_halted, 1);
    irq_is_converter <= 0; wres(); chk(cpu_service, 1);
    $display("t_cpu done");
  endtask
  task automatic t_osc();
    processor_interrupt_mask <= 3'h7;
    bus(1, `SHC_MODE_OFS, 32'h0000_0008, r);
    halt_exec <= 1; @(posedge hclk); halt_exec <= 0; wake_interrupt_a <= 1;
    @(posedge hclk); wake_interrupt_a <= 0; repeat (6) @(posedge hclk);
    chk(cpu_halted, 1); chk(sys_clk_en, 0);
    chk(wake_held, 1);
    wake_interrupt_b <= 1; wres(); wake_interrupt_b <= 0;
    chk(cpu_service, 0);
    chk(n < 8, 1);
    repeat (2) @(posedge hclk); chk(wake_held, 0);
    processor_interrupt_mask <= 3'h3;
    $display("t_osc done");
  endtask
  task automatic t_stop();
    for (int w = 0; w < 2; w++) begin
      halt(`SHC_HM_STOP, w ? 8'h10 : 8'h00);
      chk(port_oe, 0); chk(clk_out_oe, 0);
      chk(osc_en, 0); chk(periph_clk_en, 0);
      chk(osc_out_high, 1); chk(input_gate_en, 0);
      wake_interrupt_a <= 1; wres(); wake_interrupt_a <= 0;
      chk(n >= 2 * (w ? LG : SH), 1);
      chk(n < 2 * (w ? LG : SH) + 10, 1);
    end
    halt(`SHC_HM_STOP, 8'h01); chk(port_oe, 1);
    wake_interrupt_b <= 1; wres(); wake_interrupt_b <= 0;
    $display("t_stop done");
  endtask
  task automatic t_rst();
    halt(`SHC_HM_CPU, 8'h20);
    hresetn <= 0; repeat (2) @(posedge hclk); hresetn <= 1;
    @(posedge hclk); chk(cpu_halted, 0);
    bus(0, `SHC_MODE_OFS, 0, r); chk(r, 32'h0000_0080);
    $display("t_rst done");
  endtask
  task automatic results();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    hsel = 0; haddr = 0; htrans = 0; hwrite = 0; hsize = 3'h2; hwdata = 0;
    halt_exec = 0; processor_interrupt_mask = 3'h3; raise = 0; lvl = 0;
    irq_is_watchdog = 0; irq_is_converter = 0; wake_interrupt_a = 0;
    wake_interrupt_b = 0; osc_tick = 0; wdt_timeout = 0;
    repeat (4) @(posedge hclk);
    hresetn <= 1;
    t_reg(); t_cpu(); t_osc(); t_stop(); t_rst();
    results();
  end
  initial begin
    repeat (5000) @(posedge hclk);
    error_cnt++;
    results();
  end
endmodule // tb
bind shc_standby shc_chk u_chk (.*);
